/* File: logic/dopc_pkg.sv */
package dopc_pkg;

    // ==========================================================
    // sizes and timing
    localparam int unsigned NUM_CH = 8;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned MS_NS = 1_000_000;
    localparam int unsigned MS_CYC = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] STARTUP_DELAY_DEFAULT_MS = 16'd1000;
    localparam int unsigned RAMP_BASE_NS = 2560;
    localparam int unsigned RAMP_BASE_CYC = RAMP_BASE_NS / CLK_PERIOD_NS;

    // ==========================================================
    // register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DELAY = 8'h04;
    localparam logic [7:0] ADDR_RAMP = 8'h08;
    localparam logic [7:0] ADDR_UPDATE = 8'h0c;
    localparam logic [7:0] ADDR_ENABLE = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_CHAN_FIRST = 8'h20;
    localparam logic [7:0] ADDR_CHAN_LAST = 8'h3c;
    localparam int unsigned ADDR_IDX_LSB = 2;
    localparam int unsigned ADDR_IDX_MSB = 4;

    // ==========================================================
    // field positions
    localparam int unsigned CTRL_GLOBAL_EN = 0;
    localparam int unsigned CTRL_REF_DISABLE = 1;
    localparam int unsigned CTRL_DELAY_EN = 2;
    localparam int unsigned CTRL_HIGH_RATE = 3;
    localparam int unsigned CTRL_GROUP_LSB = 8;
    localparam int unsigned CTRL_GROUP_MSB = 10;
    localparam int unsigned RAMP_RISE_LSB = 0;
    localparam int unsigned RAMP_RISE_MSB = 3;
    localparam int unsigned RAMP_FALL_LSB = 4;
    localparam int unsigned RAMP_FALL_MSB = 7;
    localparam int unsigned UPDATE_BIT = 0;
    localparam int unsigned EN_PATH_LSB = 0;
    localparam int unsigned EN_PATH_MSB = 7;
    localparam int unsigned EN_FLIP_LSB = 8;
    localparam int unsigned EN_FLIP_MSB = 15;
    localparam int unsigned CHAN_GAIN_LSB = 0;
    localparam int unsigned CHAN_GAIN_MSB = 7;
    localparam int unsigned CHAN_SILENCE = 8;
    localparam int unsigned STAT_WAITING = 8;
    localparam int unsigned STAT_READY = 9;
    localparam int unsigned STAT_REFUSED = 10;
    localparam int unsigned STAT_BUSY_LSB = 16;
    localparam int unsigned STAT_BUSY_MSB = 23;

    // ==========================================================
    // gain encoding: attenuation in half-decibel steps, 0 is unity
    localparam logic [8:0] ATT_UNITY = 9'h000;
    localparam logic [8:0] ATT_SILENT = 9'h100;
    localparam logic [8:0] ATT_PER_OCTAVE = 9'h00c;
    localparam logic [16:0] LIN_UNITY = 17'h10000;

    typedef enum logic [2:0] {
        GRP_EIGHT, GRP_SIX, GRP_FOUR, GRP_TWO, GRP_ONE
    } dopc_group_t;

    typedef enum logic [1:0] {
        STRT_IDLE, STRT_WAIT, STRT_READY
    } dopc_strt_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } dopc_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [NUM_CH-1:0][31:0] data;
    } dopc_frame_t;

    // input channel that feeds output o in a grouping mode
    function automatic logic [2:0] dopc_group_src(input logic [2:0] mode, input logic [2:0] o);
        logic [2:0] src;
        src = o;
        case (mode)
            GRP_SIX: src = (o < 3'h4) ? (o >> 1) : 3'(o - 3'h2);
            GRP_FOUR: src = o >> 1;
            GRP_TWO: src = o >> 2;
            GRP_ONE: src = 3'h0;
            default: src = o;
        endcase
        return src;
    endfunction : dopc_group_src

    // attenuation steps to a linear factor, 1.0 = LIN_UNITY
    function automatic logic [16:0] dopc_att_to_lin(input logic [8:0] att);
        logic [16:0] mant;
        logic [8:0] frac;
        logic [8:0] oct;
        frac = att % ATT_PER_OCTAVE;
        oct = att / ATT_PER_OCTAVE;
        case (frac)
            9'h000: mant = 17'h10000;
            9'h001: mant = 17'h0f8b6;
            9'h002: mant = 17'h0f1a2;
            9'h003: mant = 17'h0eac1;
            9'h004: mant = 17'h0e412;
            9'h005: mant = 17'h0dd94;
            9'h006: mant = 17'h0d745;
            9'h007: mant = 17'h0d124;
            9'h008: mant = 17'h0cb30;
            9'h009: mant = 17'h0c567;
            9'h00a: mant = 17'h0bfc8;
            default: mant = 17'h0ba52;
        endcase
        return (att >= ATT_SILENT) ? 17'h00000 : (mant >> oct);
    endfunction : dopc_att_to_lin

endpackage : dopc_pkg

/* File: logic/dopc_gain_ramp.sv */
`timescale 1ns/1ps

// one control set's gain ramp toward the target latched on update
module dopc_gain_ramp (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [8:0] target_in,
    input wire logic [3:0] rise_rate,
    input wire logic [3:0] fall_rate,
    output logic [8:0] att,
    output logic busy
);
    import dopc_pkg::*;

    typedef struct packed {
        logic [8:0] att;
        logic [8:0] target;
        logic [21:0] tick;
    } dopc_ramp_st_t;

    dopc_ramp_st_t st;
    dopc_ramp_st_t next_st;
    // just wide enough to hold the slowest interval so rate code 15 cannot wrap to zero
    logic [21:0] interval;
    logic rising;

    // ==========================================================
    // step logic
    always_comb begin
        next_st = st;
        if (load) begin
            next_st.target = target_in;
        end
        rising = st.att > next_st.target;
        // rate code n gives a tick every base << n cycles
        interval = rising ? (22'(RAMP_BASE_CYC) << rise_rate) : (22'(RAMP_BASE_CYC) << fall_rate);
        if (st.att == next_st.target) begin
            next_st.tick = '0;
        end else if (st.tick >= interval - 22'h1) begin
            next_st.tick = '0;
            // one half-decibel step per tick
            next_st.att = rising ? 9'(st.att - 9'h1) : 9'(st.att + 9'h1);
        end else begin
            next_st.tick = 22'(st.tick + 22'h1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{att: ATT_UNITY, target: ATT_UNITY, tick: '0};
        end else begin
            st <= next_st;
        end
    end

    assign att = st.att;
    assign busy = st.att != st.target;

endmodule : dopc_gain_ramp

/* File: logic/dopc_sample_path.sv */
`timescale 1ns/1ps

// per-converter gain, inversion and gating, one register stage
module dopc_sample_path (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [31:0] in_sample,
    input wire logic [8:0] att,
    input wire logic flip,
    input wire logic active,
    output logic out_valid,
    output logic [31:0] out_sample
);
    import dopc_pkg::*;

    typedef struct packed {
        logic valid;
        logic [31:0] sample;
    } dopc_path_st_t;

    dopc_path_st_t st;
    dopc_path_st_t next_st;
    logic signed [49:0] prod;
    logic signed [31:0] scaled;

    // ==========================================================
    // scale, then invert; negation saturates so full negative scale stays legal
    always_comb begin
        next_st = st;
        next_st.valid = in_valid;
        prod = $signed(in_sample) * $signed({1'b0, dopc_att_to_lin(att)});
        scaled = 32'(prod >>> 16);
        if (in_valid) begin
            if (!active) begin
                next_st.sample = '0;
            end else if (flip) begin
                next_st.sample = (scaled == 32'sh80000000) ? 32'h7fffffff : 32'(-scaled);
            end else begin
                next_st.sample = scaled;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign out_valid = st.valid;
    assign out_sample = st.sample;

endmodule : dopc_sample_path

/* File: logic/dopc_output_path.sv */
`timescale 1ns/1ps

module dopc_output_path #(
    parameter int unsigned TICK_MS_CYC = dopc_pkg::MS_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire dopc_pkg::dopc_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    input wire logic hw_control_mode,
    input wire dopc_pkg::dopc_frame_t sample_in,
    output dopc_pkg::dopc_frame_t dac_out,
    output logic [7:0] converter_active
);
    import dopc_pkg::*;

    typedef struct packed {
        logic global_en;
        logic ref_disable;
        logic delay_en;
        logic high_rate;
        logic [2:0] grouping;
        logic [15:0] delay_ms;
        logic [3:0] rise_rate;
        logic [3:0] gain_fall_rate;
        logic [7:0] channel_path_enable;
        logic [7:0] channel_polarity_flip;
        logic [7:0][7:0] channel_gain;
        logic [7:0] channel_silence;
        logic gain_update_strobe;
        logic [1:0] hw_sync;
        dopc_strt_t strt;
        logic [15:0] ms_left;
        logic [15:0] presc;
        logic [7:0] active;
        logic [31:0] rdata;
    } dopc_top_st_t;

    localparam logic [15:0] PRESC_TOP = 16'(TICK_MS_CYC - 1);

    dopc_top_st_t st;
    dopc_top_st_t next_st;
    logic hw_mode;
    logic start_req;
    logic refused;
    logic chan_hit;
    logic [2:0] chan_idx;
    logic [31:0] rd_value;
    logic [7:0][8:0] ramp_att;
    logic [7:0] ramp_busy;
    logic [7:0][8:0] ramp_target;
    logic ramp_load;
    logic [7:0] path_valid;

    // ==========================================================
    // decode helpers
    assign hw_mode = st.hw_sync[1];
    assign chan_hit = bus_req.addr >= ADDR_CHAN_FIRST && bus_req.addr <= ADDR_CHAN_LAST
        && bus_req.addr[1:0] == 2'h0;
    assign chan_idx = bus_req.addr[ADDR_IDX_MSB:ADDR_IDX_LSB];
    // six and eight inputs exceed the four-input limit at the top rates
    assign refused = !hw_mode && st.high_rate
        && (st.grouping == GRP_EIGHT || st.grouping == GRP_SIX);
    assign start_req = hw_mode
        || (!st.ref_disable && st.global_en && (|st.channel_path_enable));

    // ==========================================================
    // read mux
    always_comb begin
        rd_value = '0;
        if (chan_hit) begin
            rd_value[CHAN_GAIN_MSB:CHAN_GAIN_LSB] = st.channel_gain[chan_idx];
            rd_value[CHAN_SILENCE] = st.channel_silence[chan_idx];
        end else begin
            unique case (bus_req.addr)
                ADDR_CTRL: begin
                    rd_value[CTRL_GLOBAL_EN] = st.global_en;
                    rd_value[CTRL_REF_DISABLE] = st.ref_disable;
                    rd_value[CTRL_DELAY_EN] = st.delay_en;
                    rd_value[CTRL_HIGH_RATE] = st.high_rate;
                    rd_value[CTRL_GROUP_MSB:CTRL_GROUP_LSB] = st.grouping;
                end
                ADDR_DELAY: rd_value[15:0] = st.delay_ms;
                ADDR_RAMP: begin
                    rd_value[RAMP_RISE_MSB:RAMP_RISE_LSB] = st.rise_rate;
                    rd_value[RAMP_FALL_MSB:RAMP_FALL_LSB] = st.gain_fall_rate;
                end
                ADDR_UPDATE: rd_value = '0;
                ADDR_ENABLE: begin
                    rd_value[EN_PATH_MSB:EN_PATH_LSB] = st.channel_path_enable;
                    rd_value[EN_FLIP_MSB:EN_FLIP_LSB] = st.channel_polarity_flip;
                end
                ADDR_STATUS: begin
                    rd_value[EN_PATH_MSB:EN_PATH_LSB] = st.active;
                    rd_value[STAT_WAITING] = st.strt == STRT_WAIT;
                    rd_value[STAT_READY] = st.strt == STRT_READY;
                    rd_value[STAT_REFUSED] = refused;
                    rd_value[STAT_BUSY_MSB:STAT_BUSY_LSB] = ramp_busy;
                end
                default: rd_value = '0;
            endcase
        end
    end

    // ==========================================================
    // register writes, startup sequencing, path gating
    always_comb begin
        next_st = st;
        next_st.hw_sync = {st.hw_sync[0], hw_control_mode};
        next_st.gain_update_strobe = 1'b0;
        next_st.rdata = bus_req.rd ? rd_value : '0;
        if (bus_req.wr) begin
            if (chan_hit) begin
                // held pending until the update strobe
                next_st.channel_gain[chan_idx] = bus_req.wdata[CHAN_GAIN_MSB:CHAN_GAIN_LSB];
                next_st.channel_silence[chan_idx] = bus_req.wdata[CHAN_SILENCE];
            end else begin
                unique case (bus_req.addr)
                    ADDR_CTRL: begin
                        next_st.global_en = bus_req.wdata[CTRL_GLOBAL_EN];
                        next_st.ref_disable = bus_req.wdata[CTRL_REF_DISABLE];
                        next_st.delay_en = bus_req.wdata[CTRL_DELAY_EN];
                        next_st.high_rate = bus_req.wdata[CTRL_HIGH_RATE];
                        // codes above the one-group mode fall back to eight
                        next_st.grouping = (bus_req.wdata[CTRL_GROUP_MSB:CTRL_GROUP_LSB] > GRP_ONE)
                            ? GRP_EIGHT : bus_req.wdata[CTRL_GROUP_MSB:CTRL_GROUP_LSB];
                    end
                    ADDR_DELAY: next_st.delay_ms = bus_req.wdata[15:0];
                    ADDR_RAMP: begin
                        next_st.rise_rate = bus_req.wdata[RAMP_RISE_MSB:RAMP_RISE_LSB];
                        next_st.gain_fall_rate = bus_req.wdata[RAMP_FALL_MSB:RAMP_FALL_LSB];
                    end
                    ADDR_UPDATE: next_st.gain_update_strobe = bus_req.wdata[UPDATE_BIT];
                    ADDR_ENABLE: begin
                        next_st.channel_path_enable = bus_req.wdata[EN_PATH_MSB:EN_PATH_LSB];
                        next_st.channel_polarity_flip = bus_req.wdata[EN_FLIP_MSB:EN_FLIP_LSB];
                    end
                    default: begin
                    end
                endcase
            end
        end
        // startup delay, counted in milliseconds
        unique case (st.strt)
            STRT_IDLE: begin
                if (start_req) begin
                    next_st.ms_left = st.delay_ms;
                    next_st.presc = PRESC_TOP;
                    next_st.strt = (st.delay_en && st.delay_ms != 16'h0)
                        ? STRT_WAIT : STRT_READY;
                end
            end
            STRT_WAIT: begin
                if (st.presc == 16'h0) begin
                    next_st.presc = PRESC_TOP;
                    next_st.ms_left = 16'(st.ms_left - 16'h1);
                    if (st.ms_left <= 16'h1) begin
                        next_st.strt = STRT_READY;
                    end
                end else begin
                    next_st.presc = 16'(st.presc - 16'h1);
                end
            end
            STRT_READY: begin
            end
        endcase
        // a reference disable re-arms the delay for the next enable
        if (st.ref_disable && !hw_mode) begin
            next_st.strt = STRT_IDLE;
        end
        for (int o = 0; o < NUM_CH; o++) begin
            // converters of a group follow their group's enable
            next_st.active[o] = st.strt == STRT_READY && !refused && (hw_mode
                || (st.global_en && !st.ref_disable
                && st.channel_path_enable[dopc_group_src(st.grouping, 3'(o))]));
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '{
                global_en: 1'b0, ref_disable: 1'b0, delay_en: 1'b1, high_rate: 1'b0,
                grouping: GRP_EIGHT, delay_ms: STARTUP_DELAY_DEFAULT_MS,
                rise_rate: '0, gain_fall_rate: '0, channel_path_enable: '0,
                channel_polarity_flip: '0, channel_gain: '0, channel_silence: '0,
                gain_update_strobe: 1'b0, hw_sync: '0, strt: STRT_IDLE,
                ms_left: '0, presc: '0, active: '0, rdata: '0
            };
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // gain ramps, one per control set; strapped mode pins unity gain
    assign ramp_load = st.gain_update_strobe || hw_mode;
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            if (hw_mode) begin
                ramp_target[i] = ATT_UNITY;
            end else if (st.channel_silence[i]) begin
                ramp_target[i] = ATT_SILENT;
            end else begin
                ramp_target[i] = {1'b0, st.channel_gain[i]};
            end
        end
    end

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ramp
        dopc_gain_ramp u_ramp (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .load(ramp_load),
            .target_in(ramp_target[i]),
            .rise_rate(st.rise_rate),
            .fall_rate(st.gain_fall_rate),
            .att(ramp_att[i]),
            .busy(ramp_busy[i])
        );
    end

    // ==========================================================
    // routing: each converter takes its group's sample and control set
    for (genvar o = 0; o < NUM_CH; o++) begin : g_path
        logic [2:0] src;
        assign src = dopc_group_src(st.grouping, 3'(o));
        dopc_sample_path u_path (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .in_valid(sample_in.valid),
            .in_sample(sample_in.data[src]),
            .att(ramp_att[src]),
            .flip(st.channel_polarity_flip[src] && !hw_mode),
            .active(st.active[o]),
            .out_valid(path_valid[o]),
            .out_sample(dac_out.data[o])
        );
    end

    assign dac_out.valid = path_valid[0];
    assign bus_rdata = st.rdata;
    assign converter_active = st.active;

endmodule : dopc_output_path

/* File: verification/dopc_sample_source.sv */
`timescale 1ns/1ps

// audio frame source standing in for the serial audio input
module dopc_sample_source (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [3:0] gap,
    output dopc_pkg::dopc_frame_t frame
);
    import dopc_pkg::*;
    logic [3:0] cnt;

    // halved samples never hit the most negative code; idle data toggles each cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame <= '0;
            cnt <= 4'h0;
        end else if (go && cnt == 4'h0) begin
            frame.valid <= 1'b1;
            for (int i = 0; i < 8; i++) begin
                frame.data[i] <= 32'($signed($urandom) >>> 1);
            end
            cnt <= gap;
        end else begin
            frame.valid <= 1'b0;
            frame.data <= ~frame.data;
            cnt <= (cnt == 4'h0) ? 4'h0 : cnt - 4'h1;
        end
    end
endmodule : dopc_sample_source

/* File: verification/dopc_output_path_monitor.sv */
`timescale 1ns/1ps

module dopc_output_path_monitor #(
    parameter int unsigned TICK_MS_CYC = dopc_pkg::MS_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire dopc_pkg::dopc_bus_req_t bus_req,
    input wire logic [31:0] bus_rdata,
    input wire logic hw_control_mode,
    input wire dopc_pkg::dopc_frame_t sample_in,
    input wire dopc_pkg::dopc_frame_t dac_out,
    input wire logic [7:0] converter_active
);
    import dopc_pkg::*;
    default clocking mon_cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // control and enable writes that must shut every converter off
    sequence ctrl_wr;
        bus_req.wr && bus_req.addr == ADDR_CTRL && !hw_control_mode;
    endsequence
    chk_ref_off: assert property (ctrl_wr ##0 bus_req.wdata[1] |-> ##[1:3] converter_active == 8'h00)
        else $error("converters alive under reference disable");
    chk_global_off: assert property (ctrl_wr ##0 !bus_req.wdata[0] |-> ##[1:3] converter_active == 8'h00)
        else $error("converters alive with global enable clear");
    chk_rate_refuse: assert property (ctrl_wr ##0 (bus_req.wdata[3] && bus_req.wdata[10:8] < 3'h2)
        |-> ##[1:3] converter_active == 8'h00) else $error("high rate accepted with too many inputs");
    chk_enable_off: assert property (bus_req.wr && bus_req.addr == ADDR_ENABLE && bus_req.wdata[7:0] == 8'h00
        && !hw_control_mode |-> ##[1:3] converter_active == 8'h00) else $error("converter alive without enable");

    // ==========================================================
    // read port and sample stream timing
    chk_rdata_idle: assert property (!bus_req.rd |=> bus_rdata == 32'h0)
        else $error("read data outside read slot");
    chk_update_zero: assert property (bus_req.rd && bus_req.addr == ADDR_UPDATE |=> bus_rdata == 32'h0)
        else $error("update strobe reads nonzero");
    chk_valid_follow: assert property (sample_in.valid |=> dac_out.valid)
        else $error("frame not passed on");
    chk_valid_only: assert property (!sample_in.valid |=> !dac_out.valid)
        else $error("output frame without input frame");
    // a converter idle for two cycles must put out silence
    for (genvar o = 0; o < 8; o++) begin : g_quiet
        chk_quiet_zero: assert property ((!converter_active[o]) [*2] ##0 dac_out.valid |-> dac_out.data[o] == 32'h0)
            else $error("inactive converter carries data");
    end
endmodule : dopc_output_path_monitor

bind dopc_output_path dopc_output_path_monitor #(.TICK_MS_CYC(TICK_MS_CYC)) u_mon (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .hw_control_mode(hw_control_mode), .sample_in(sample_in), .dac_out(dac_out),
    .converter_active(converter_active));

/* File: verification/test_dopc_output_path.sv */
`timescale 1ns/1ps

module test_dopc_output_path;
    import dopc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n;
    logic hw;
    logic go;
    logic [3:0] gap;
    logic [2:0] mode;
    logic [7:0] fl;
    logic [7:0] act;
    logic [31:0] rdata;
    logic [16:0] lin [8];
    dopc_bus_req_t req;
    dopc_frame_t sin;
    dopc_frame_t dout;
    int error_cnt;
    int checked;
    int n;

    // ==========================================================
    // clock, design and frame source
    always #20 sys_clk = ~sys_clk;
    dopc_output_path #(.TICK_MS_CYC(4)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(req),
        .bus_rdata(rdata), .hw_control_mode(hw), .sample_in(sin), .dac_out(dout),
        .converter_active(act));
    dopc_sample_source u_src (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .gap(gap), .frame(sin));

    // ==========================================================
    // expectations and bus helpers
    function automatic int grp_src(input int o);
        case (mode)
            3'h1: return (o < 4) ? o / 2 : o - 2;
            3'h2: return o / 2;
            3'h3: return o / 4;
            3'h4: return 0;
            default: return o;
        endcase
    endfunction : grp_src
    // scale first, then flip, as the sample path does
    function automatic logic [31:0] expv(input logic [31:0] s, input logic [16:0] g, input logic f);
        logic signed [63:0] p;
        p = ($signed(s) * $signed({15'h0, g})) >>> 16;
        return f ? 32'(-p) : p[31:0];
    endfunction : expv
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1 cmp(rdata, exp);
    endtask : rd
    // bounded wait for a converter pattern; n gives the cycles spent
    task automatic wait_act(input logic [7:0] exp);
        n = 0;
        while (act !== exp && n < 6000) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (n >= 6000) begin
            error_cnt++;
            finish_test();
        end
    endtask : wait_act
    task automatic frame_chk();
        logic [7:0][31:0] d;
        int s;
        gap <= 4'($urandom_range(3));
        n = 0;
        do begin
            @(posedge sys_clk);
            #1 n++;
        end while (sin.valid !== 1'b1 && n < 40);
        if (n >= 40) begin
            error_cnt++;
            finish_test();
        end
        d = sin.data;
        @(posedge sys_clk);
        #1 cmp(32'(dout.valid), 32'h1);
        for (int o = 0; o < 8; o++) begin
            s = grp_src(o);
            cmp(dout.data[o], expv(d[s], lin[s], fl[s]));
        end
    endtask : frame_chk

    // ==========================================================
    // main sequence
    initial begin
        rst_n = 1'b0;
        hw = 1'b0;
        go = 1'b0;
        gap = 4'h0;
        req = '0;
        mode = 3'h0;
        error_cnt = 0;
        checked = 0;
        void'($urandom(32'hd1d666c5));
        fl = 8'($urandom);
        for (int i = 0; i < 8; i++) lin[i] = LIN_UNITY;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        go <= 1'b1;
        rd(ADDR_CTRL, 32'h4);
        rd(ADDR_DELAY, 32'h3e8);
        rd(8'h18, 32'h0);
        // short programmed delay must still hold the paths back
        wr(ADDR_DELAY, 32'h3);
        wr(ADDR_ENABLE, {16'h0, fl, 8'hff});
        wr(ADDR_CTRL, 32'h5);
        rd(ADDR_STATUS, 32'h100);
        wait_act(8'hff);
        cmp(32'(n >= 8), 32'h1);
        // global enable is dropped around every regrouping
        for (int m = 0; m < 5; m++) begin
            wr(ADDR_CTRL, 32'h4 | (m << 8));
            wr(ADDR_CTRL, 32'h5 | (m << 8));
            mode = 3'(m);
            wait_act(8'hff);
            frame_chk();
        end
        wr(ADDR_CTRL, 32'h704);
        rd(ADDR_CTRL, 32'h4);
        mode = 3'h0;
        wr(ADDR_CTRL, 32'hd);
        wait_act(8'h00);
        rd(ADDR_STATUS, 32'h600);
        wr(ADDR_CTRL, 32'hc);
        wr(ADDR_CTRL, 32'h20d);
        mode = 3'h2;
        wait_act(8'hff);
        // reference disable rearms the startup delay
        wr(ADDR_CTRL, 32'h20f);
        wait_act(8'h00);
        wr(ADDR_CTRL, 32'h20d);
        rd(ADDR_STATUS, 32'h100);
        wait_act(8'hff);
        // gain and silence stay pending until the strobe
        wr(ADDR_CHAN_FIRST, 32'h2);
        wr(ADDR_CHAN_FIRST + 8'h4, 32'h100);
        frame_chk();
        rd(ADDR_CHAN_FIRST, 32'h2);
        wr(ADDR_UPDATE, 32'h1);
        rd(ADDR_STATUS, 32'h302ff);
        rd(ADDR_UPDATE, 32'h0);
        repeat (16500) @(posedge sys_clk); // rates left alone while ramping
        lin[0] = 17'h0f1a2;
        lin[1] = 17'h0;
        frame_chk();
        rd(ADDR_STATUS, 32'h2ff);
        wr(ADDR_CTRL, 32'h204);
        wr(ADDR_CTRL, 32'h4);
        mode = 3'h0;
        wr(ADDR_ENABLE, 32'h0);
        wait_act(8'h00);
        // strapped mode overrides enables, gains and flips
        hw <= 1'b1;
        fl = 8'h0;
        for (int i = 0; i < 8; i++) lin[i] = LIN_UNITY;
        wait_act(8'hff);
        // silenced and attenuated sets ramp back to unity first
        repeat (16500) @(posedge sys_clk);
        frame_chk();
        finish_test();
    end
endmodule : test_dopc_output_path
